// ===== genset_pkg.sv
`default_nettype none

package genset_pkg;

    // Clock and time base
    localparam int          CLK_PERIOD_NS   = 20;
    localparam longint      TICK_PERIOD_NS  = 100_000_000;
    localparam int          TICK_CYCLES     = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
    localparam int          TICK_CNT_W      = 32;

    // Timer counts in time-base ticks
    localparam int          CNT_W            = 16;
    localparam logic [15:0] RETURN_DELAY_RST = 16'h012C;
    localparam logic [15:0] COOLING_RST      = 16'h0258;

    // Register map, byte addresses
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam logic [7:0]  REG_RETURN_DELAY = 8'h00;
    localparam logic [7:0]  REG_COOLING      = 8'h04;
    localparam logic [7:0]  REG_STATUS       = 8'h08;
    localparam logic [7:0]  REG_ALARM        = 8'h0C;

    // Status register field positions
    localparam int          STAT_MODE_LSB    = 0;
    localparam int          STAT_SEQ_LSB     = 4;
    localparam int          STAT_CMD_LSB     = 8;

    typedef enum logic [1:0] {MODE_STOP, MODE_MANUAL, MODE_AUTO} mode_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_RUN_OFF,
        SEQ_SYNC,
        SEQ_ON_LOAD,
        SEQ_RETURN_DLY,
        SEQ_RAMP,
        SEQ_COOL
    } seq_t;

    // Front-panel buttons
    typedef struct packed {
        logic stop_mode;
        logic manual_mode;
        logic auto_mode;
        logic start;
        logic transfer;
        logic open_load;
    } button_t;

    // Configurable digital inputs
    typedef struct packed {
        logic transfer;
        logic open_load;
        logic on_load;
    } dig_in_t;

    // Feedback from generator, synchroniser and load ramp
    typedef struct packed {
        logic available;
        logic in_sync;
        logic ramp_done;
    } gen_fb_t;

    // Commands towards engine and breaker
    typedef struct packed {
        logic engine_run;
        logic breaker_close;
        logic sync_request;
        logic ramp_off_request;
    } gen_cmd_t;

    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : genset_pkg

`default_nettype wire

// ===== timebase_tick.sv
`timescale 1ns/1ps
`default_nettype none

module timebase_tick
    import genset_pkg::*;
#(
    parameter int DIV = TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    output var  logic tick
);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] cnt;
        logic                  tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;

    // Free-running divider, one-cycle pulse per period
    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt == TICK_CNT_W'(DIV - 1))
        begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;

endmodule : timebase_tick

`default_nettype wire

// ===== genset_mode_sequencer.sv
// Summary of operation
// - In stop mode the engine is kept at rest and never commanded to run.
// - Entering stop mode clears latched alarms whose input is gone and opens the breaker.
// - In manual mode a start press runs the engine off load with the breaker open.
// - In manual mode a transfer requests synchronisation and closes the breaker only once in sync.
// - In manual mode an open ramps the load off first and then opens the breaker.
// - Transfer and open digital inputs give the same sequences as their buttons.
// - Running off load in manual, a rising on-load input synchronises and then closes the breaker.
// - Removing the on-load input in manual leaves the breaker closed until an open is given or stop or auto is chosen.
// - The auto button selects automatic mode in which the sequencer alone starts, loads and stops.
// - In auto any start request, local or from the multiset link, starts the engine.
// - In auto an available generator is synchronised and then the breaker closes.
// - In auto removal of all requests starts the return-delay timer before any unloading.
// - On return-delay expiry the load is ramped off and then the breaker opens.
// - After the breaker opens in auto the engine cools unloaded and stops only when cooling ends.
// - After stopping in auto the sequencer idles awaiting a new request.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module genset_mode_sequencer
    import genset_pkg::*;
#(
    parameter int          REQ_W       = 4,
    parameter int          LINK_W      = 8,
    parameter int          ALARM_W     = 8,
    parameter int          TICK_DIV    = TICK_CYCLES,
    parameter logic [15:0] RET_DEFAULT = RETURN_DELAY_RST,
    parameter logic [15:0] COOL_DEFAULT = COOLING_RST
)
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire button_t            buttons,
    input  wire dig_in_t            dig_in,
    input  wire gen_fb_t            gen_fb,
    input  wire logic [REQ_W-1:0]   start_req,
    input  wire logic [LINK_W-1:0]  multiset_comms_link,
    input  wire logic [ALARM_W-1:0] alarm_in,
    input  wire reg_req_t           reg_req,
    output var  logic [DATA_W-1:0]  reg_rdata,
    output var  gen_cmd_t           gen_cmd,
    output var  mode_t              mode,
    output var  logic [ALARM_W-1:0] alarm_latched
);

    localparam int RQ_W = REQ_W + LINK_W;

    typedef struct packed {
        mode_t              mode;
        seq_t               seq;
        gen_cmd_t           cmd;
        logic [CNT_W-1:0]   tmr;
        logic [CNT_W-1:0]   ret_cfg;
        logic [CNT_W-1:0]   cool_cfg;
        logic [ALARM_W-1:0] alarm;
        logic [DATA_W-1:0]  rdata;
        button_t            btn_s1;
        button_t            btn_s2;
        button_t            btn_s3;
        dig_in_t            din_s1;
        dig_in_t            din_s2;
        dig_in_t            din_s3;
        gen_fb_t            fb_s1;
        gen_fb_t            fb_s2;
        logic [RQ_W-1:0]    req_s1;
        logic [RQ_W-1:0]    req_s2;
        logic [ALARM_W-1:0] alm_s1;
        logic [ALARM_W-1:0] alm_s2;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;
    logic       tick;
    button_t    press;
    dig_in_t    din_rise;
    logic       any_req;
    logic       transfer_evt;
    logic       open_evt;
    logic       entering_stop;

    // Common time base for both timers
    timebase_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // Edges and merged events from synchronised inputs
    always_comb
    begin
        press         = st.btn_s2 & ~st.btn_s3;
        din_rise      = st.din_s2 & ~st.din_s3;
        any_req       = |st.req_s2;
        transfer_evt  = press.transfer | din_rise.transfer;
        open_evt      = press.open_load | din_rise.open_load;
        entering_stop = press.stop_mode && (st.mode != MODE_STOP);
    end

    // Next state of the whole sequencer
    always_comb
    begin
        next_st        = st;
        next_st.btn_s1 = buttons;
        next_st.btn_s2 = st.btn_s1;
        next_st.btn_s3 = st.btn_s2;
        next_st.din_s1 = dig_in;
        next_st.din_s2 = st.din_s1;
        next_st.din_s3 = st.din_s2;
        next_st.fb_s1  = gen_fb;
        next_st.fb_s2  = st.fb_s1;
        next_st.req_s1 = {multiset_comms_link, start_req};
        next_st.req_s2 = st.req_s1;
        next_st.alm_s1 = alarm_in;
        next_st.alm_s2 = st.alm_s1;

        // Mode select, stop has priority
        if (press.stop_mode)
            next_st.mode = MODE_STOP;
        else if (press.manual_mode)
            next_st.mode = MODE_MANUAL;
        else if (press.auto_mode)
            next_st.mode = MODE_AUTO;

        // Alarm latch; a new alarm wins over the clear
        next_st.alarm = (entering_stop ? (st.alarm & st.alm_s2) : st.alarm) | st.alm_s2;

        // Timer countdown on the common tick
        if (tick && (st.tmr != '0))
            next_st.tmr = st.tmr - 1'b1;

        if (next_st.mode == MODE_STOP)
        begin
            next_st.seq = SEQ_IDLE;
        end
        else if (next_st.mode == MODE_MANUAL)
        begin
            unique case (st.seq)
                SEQ_IDLE:
                    if (press.start)
                        next_st.seq = SEQ_RUN_OFF;
                SEQ_RUN_OFF:
                    if (st.fb_s2.available && (transfer_evt || din_rise.on_load))
                        next_st.seq = SEQ_SYNC;
                SEQ_SYNC:
                    if (st.fb_s2.in_sync)
                        next_st.seq = SEQ_ON_LOAD;
                SEQ_ON_LOAD:
                    if (open_evt)
                        next_st.seq = SEQ_RAMP;
                SEQ_RETURN_DLY:
                    next_st.seq = SEQ_ON_LOAD;
                SEQ_RAMP:
                    if (st.fb_s2.ramp_done)
                        next_st.seq = SEQ_RUN_OFF;
                SEQ_COOL:
                    next_st.seq = SEQ_RUN_OFF;
            endcase
        end
        else
        begin
            unique case (st.seq)
                SEQ_IDLE:
                    if (any_req)
                        next_st.seq = SEQ_RUN_OFF;
                SEQ_RUN_OFF, SEQ_SYNC:
                    if (!any_req)
                    begin
                        next_st.seq = SEQ_COOL;
                        next_st.tmr = st.cool_cfg;
                    end
                    else if (st.seq == SEQ_RUN_OFF && st.fb_s2.available)
                        next_st.seq = SEQ_SYNC;
                    else if (st.seq == SEQ_SYNC && st.fb_s2.in_sync)
                        next_st.seq = SEQ_ON_LOAD;
                SEQ_ON_LOAD:
                    if (!any_req)
                    begin
                        next_st.seq = SEQ_RETURN_DLY;
                        next_st.tmr = st.ret_cfg;
                    end
                SEQ_RETURN_DLY:
                    if (any_req)
                        next_st.seq = SEQ_ON_LOAD;
                    else if (st.tmr == '0)
                        next_st.seq = SEQ_RAMP;
                SEQ_RAMP:
                    if (st.fb_s2.ramp_done)
                    begin
                        next_st.seq = SEQ_COOL;
                        next_st.tmr = st.cool_cfg;
                    end
                SEQ_COOL:
                    if (any_req)
                        next_st.seq = SEQ_RUN_OFF;
                    else if (st.tmr == '0)
                        next_st.seq = SEQ_IDLE;
            endcase
        end

        // Commands decoded from the new sequence state
        next_st.cmd.engine_run       = (next_st.seq != SEQ_IDLE);
        next_st.cmd.breaker_close    = (next_st.seq == SEQ_ON_LOAD) ||
                                       (next_st.seq == SEQ_RETURN_DLY) ||
                                       (next_st.seq == SEQ_RAMP);
        next_st.cmd.sync_request     = (next_st.seq == SEQ_SYNC);
        next_st.cmd.ramp_off_request = (next_st.seq == SEQ_RAMP);

        // Register writes
        if (reg_req.wr && (reg_req.addr == REG_RETURN_DELAY))
            next_st.ret_cfg = reg_req.wdata[CNT_W-1:0];
        if (reg_req.wr && (reg_req.addr == REG_COOLING))
            next_st.cool_cfg = reg_req.wdata[CNT_W-1:0];

        // Register reads, data valid for one cycle only
        next_st.rdata = '0;
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                REG_RETURN_DELAY: next_st.rdata = DATA_W'(st.ret_cfg);
                REG_COOLING:      next_st.rdata = DATA_W'(st.cool_cfg);
                REG_STATUS:
                begin
                    next_st.rdata[STAT_MODE_LSB +: 2] = st.mode;
                    next_st.rdata[STAT_SEQ_LSB +: 3]  = st.seq;
                    next_st.rdata[STAT_CMD_LSB +: 4]  = st.cmd;
                end
                REG_ALARM:        next_st.rdata = DATA_W'(st.alarm);
                default:          next_st.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st          <= '0;
            st.ret_cfg  <= RET_DEFAULT;
            st.cool_cfg <= COOL_DEFAULT;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata     = st.rdata;
    assign gen_cmd       = st.cmd;
    assign mode          = st.mode;
    assign alarm_latched = st.alarm;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Stop mode keeps the set at rest
    stop_at_rest_a: assert property (st.mode == MODE_STOP |-> !st.cmd.engine_run && !st.cmd.breaker_close)
        else $error("engine or breaker commanded in stop mode");

    // Stop entry clears alarms no longer present
    stop_alarm_clear_a: assert property (entering_stop |=> st.alarm == $past(st.alm_s2))
        else $error("stale alarm kept on stop entry");

    // Manual start runs off load
    manual_start_a: assert property (st.mode == MODE_MANUAL && st.seq == SEQ_IDLE && press.start &&
        !press.stop_mode && !press.auto_mode |=> st.cmd.engine_run && !st.cmd.breaker_close)
        else $error("manual start did not run off load");

    // Breaker closes only after sync reported
    close_after_sync_a: assert property ($rose(st.cmd.breaker_close) |-> $past(st.fb_s2.in_sync) &&
        $past(st.seq) == SEQ_SYNC)
        else $error("breaker closed without sync");

    // Breaker opens in a mode only after ramp done
    open_after_ramp_a: assert property ($fell(st.cmd.breaker_close) && st.mode != MODE_STOP &&
        st.mode == $past(st.mode) |-> $past(st.fb_s2.ramp_done))
        else $error("breaker opened before load ramped off");

    // Manual on-load holds until an open
    manual_hold_a: assert property (st.mode == MODE_MANUAL && st.seq == SEQ_ON_LOAD && !open_evt &&
        !press.stop_mode && !press.auto_mode |=> st.cmd.breaker_close)
        else $error("manual load dropped without open");

    // Mode press takes effect next cycle
    mode_press_a: assert property (press.auto_mode && !press.stop_mode && !press.manual_mode |=>
        st.mode == MODE_AUTO)
        else $error("auto press not applied");

    // Auto request starts engine
    auto_start_a: assert property (st.mode == MODE_AUTO && st.seq == SEQ_IDLE && any_req &&
        !press.stop_mode && !press.manual_mode |=> st.cmd.engine_run)
        else $error("auto request did not start engine");

    // Request removal holds load through return delay
    return_delay_a: assert property (st.mode == MODE_AUTO && st.seq == SEQ_ON_LOAD && !any_req &&
        !press.stop_mode && !press.manual_mode |=> st.seq == SEQ_RETURN_DLY && st.cmd.breaker_close)
        else $error("return delay not started");

    // Engine stop in auto only out of cooling
    cool_stop_a: assert property ($fell(st.cmd.engine_run) && st.mode == MODE_AUTO &&
        $past(st.mode) == MODE_AUTO |-> $past(st.seq) == SEQ_COOL && $past(st.tmr) == '0)
        else $error("engine stopped before cooling ended");

    auto_cycle_c:    cover property (st.seq == SEQ_COOL ##1 st.seq == SEQ_IDLE && st.mode == MODE_AUTO);
    manual_load_c:   cover property (st.mode == MODE_MANUAL && $rose(st.cmd.breaker_close));
    stop_on_load_c:  cover property (entering_stop && st.cmd.breaker_close);
    ret_cancel_c:    cover property (st.seq == SEQ_RETURN_DLY ##1 st.seq == SEQ_ON_LOAD);

endmodule : genset_mode_sequencer

`default_nettype wire

// ===== genset_partner.sv
`timescale 1ns/1ps
`default_nettype none

module genset_partner
    import genset_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     sys_rst,
    input  wire logic     slow,
    input  wire gen_cmd_t gen_cmd,
    output var  gen_fb_t  gen_fb
);
    logic [3:0] lim;
    logic [3:0] run_cnt;
    logic [3:0] syn_cnt;
    logic [3:0] rmp_cnt;

    // Count up while commanded, saturate at the limit, clear when withdrawn
    function automatic logic [3:0] step(input logic [3:0] c, input logic on, input logic [3:0] l);
        return !on ? 4'h0 : (c == l ? c : c + 4'h1);
    endfunction : step

    // Short or long response of the engine, synchroniser and ramp
    assign lim = slow ? 4'hC : 4'h2;

    // Feedback counters
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run_cnt <= 4'h0;
            syn_cnt <= 4'h0;
            rmp_cnt <= 4'h0;
        end
        else
        begin
            run_cnt <= step(run_cnt, gen_cmd.engine_run, lim);
            syn_cnt <= step(syn_cnt, gen_cmd.sync_request, lim);
            rmp_cnt <= step(rmp_cnt, gen_cmd.ramp_off_request, lim);
        end
    end

    // Feedback levels drop on the first clock edge after the command goes away
    assign gen_fb.available = (run_cnt == lim);
    assign gen_fb.in_sync   = (syn_cnt == lim);
    assign gen_fb.ramp_done = (rmp_cnt == lim);
endmodule : genset_partner

`default_nettype wire

// ===== genset_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module genset_mode_sequencer_tb
    import genset_pkg::*;
;
    localparam int      RUN    = 3;
    localparam int      BRK    = 2;
    localparam int      SYN    = 1;
    localparam int      RMP    = 0;
    localparam button_t B_STOP = 6'h20;
    localparam button_t B_MAN  = 6'h10;
    localparam button_t B_AUTO = 6'h08;
    localparam button_t B_GO   = 6'h04;
    localparam button_t B_XFER = 6'h02;
    localparam button_t B_OPEN = 6'h01;

    logic        clk;
    logic        sys_rst;
    logic        slow;
    button_t     buttons;
    dig_in_t     dig_in;
    gen_fb_t     gen_fb;
    logic [3:0]  start_req;
    logic [7:0]  multiset_comms_link;
    logic [7:0]  alarm_in;
    reg_req_t    reg_req;
    logic [31:0] reg_rdata;
    gen_cmd_t    gen_cmd;
    mode_t       mode;
    logic [7:0]  alarm_latched;
    int          n_mismatch;
    int          checks;
    int          cyc;

    genset_mode_sequencer #(.TICK_DIV(4), .RET_DEFAULT(16'h0005), .COOL_DEFAULT(16'h0006)) dut (
        .clk(clk), .sys_rst(sys_rst), .buttons(buttons), .dig_in(dig_in), .gen_fb(gen_fb),
        .start_req(start_req), .multiset_comms_link(multiset_comms_link), .alarm_in(alarm_in),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .gen_cmd(gen_cmd), .mode(mode),
        .alarm_latched(alarm_latched));

    genset_partner far_side (.clk(clk), .sys_rst(sys_rst), .slow(slow), .gen_cmd(gen_cmd), .gen_fb(gen_fb));

    // Clock at 50 MHz
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // Wait a bounded time for one command bit, then judge it
    task automatic wait_cmd(input int b, input logic v, input int lim);
        @(negedge clk);
        for (int i = 0; i < lim && gen_cmd[b] !== v; i++)
            @(negedge clk);
        check(gen_cmd[b], v);
        @(posedge clk);
    endtask : wait_cmd

    // Hold a button past the synchroniser, release, return while the sequence is still in its first step
    task automatic press(input button_t m);
        buttons <= m;
        wait_cyc(4);
        buttons <= 6'h00;
        wait_cyc(1);
    endtask : press

    // Same shape for a digital input pulse
    task automatic pulse_din(input dig_in_t m);
        dig_in <= m;
        wait_cyc(4);
        dig_in <= 3'h0;
        wait_cyc(1);
    endtask : pulse_din

    // Write leaves the strobe up for the next access to replace
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
        @(posedge clk);
        reg_req <= '0;
        @(negedge clk);
        check(reg_rdata, exp);
        @(posedge clk);
    endtask : reg_rd

    task automatic t_regs;
        reg_rd(REG_RETURN_DELAY, 32'h00000005);
        reg_rd(REG_COOLING, 32'h00000006);
        reg_wr(REG_RETURN_DELAY, 32'hFFFF0003);
        reg_wr(REG_COOLING, 32'h00000004);
        reg_rd(REG_RETURN_DELAY, 32'h00000003);
        reg_rd(REG_COOLING, 32'h00000004);
        reg_wr(REG_STATUS, 32'hFFFFFFFF);
        reg_rd(REG_STATUS, 32'h00000000);
        reg_rd(8'h10, 32'h00000000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_stop;
        press(B_GO);
        start_req <= 4'hF;
        wait_cyc(20);
        @(negedge clk);
        check(gen_cmd, 4'h0);
        check(mode, MODE_STOP);
        start_req <= 4'h0;
        @(posedge clk);
        $display("test stop done");
    endtask : t_stop

    // Close by button, digital input or on-load input
    task automatic man_close(input int src);
        if (src == 0)
            press(B_XFER);
        else if (src == 1)
            pulse_din(3'h4);
        else
            dig_in <= 3'h1;
        wait_cmd(SYN, 1'b1, 40);
        wait_cmd(BRK, 1'b0, 0);
        wait_cmd(BRK, 1'b1, 40);
    endtask : man_close

    task automatic man_open(input int src);
        if (src == 0)
            press(B_OPEN);
        else
            pulse_din(3'h2);
        wait_cmd(RMP, 1'b1, 40);
        wait_cmd(BRK, 1'b1, 0);
        wait_cmd(BRK, 1'b0, 40);
    endtask : man_open

    task automatic t_manual;
        press(B_MAN);
        alarm_in <= 8'h01;
        wait_cyc(3);
        alarm_in <= 8'h00;
        wait_cyc(4);
        @(negedge clk);
        check(mode, MODE_MANUAL);
        check(alarm_latched, 8'h01);
        press(B_GO);
        wait_cmd(RUN, 1'b1, 20);
        wait_cmd(BRK, 1'b0, 0);
        wait_cyc(10);
        man_close(0);
        man_open(1);
        man_close(1);
        man_open(0);
        man_close(2);
        dig_in <= 3'h0;
        wait_cyc(30);
        wait_cmd(BRK, 1'b1, 0);
        reg_rd(REG_ALARM, 32'h00000001);
        press(B_STOP);
        @(negedge clk);
        check(gen_cmd, 4'h0);
        check(alarm_latched, 8'h00);
        check(mode, MODE_STOP);
        @(posedge clk);
        $display("test manual done");
    endtask : t_manual

    task automatic t_auto;
        slow <= 1'b1;
        press(B_AUTO);
        @(negedge clk);
        check(mode, MODE_AUTO);
        @(posedge clk);
        multiset_comms_link <= 8'h80;
        wait_cmd(RUN, 1'b1, 40);
        wait_cmd(SYN, 1'b1, 80);
        wait_cmd(BRK, 1'b0, 0);
        wait_cmd(BRK, 1'b1, 80);
        multiset_comms_link <= 8'h00;
        wait_cyc(8);
        wait_cmd(RMP, 1'b0, 0);
        wait_cmd(BRK, 1'b1, 0);
        wait_cmd(RMP, 1'b1, 80);
        wait_cmd(BRK, 1'b0, 80);
        wait_cmd(RUN, 1'b1, 0);
        wait_cyc(8);
        wait_cmd(RUN, 1'b1, 0);
        wait_cmd(RUN, 1'b0, 80);
        wait_cyc(10);
        reg_rd(REG_STATUS, 32'h00000002);
        start_req <= 4'h1;
        wait_cmd(RUN, 1'b1, 40);
        start_req <= 4'h0;
        press(B_STOP);
        wait_cmd(RUN, 1'b0, 0);
        $display("test auto done");
    endtask : t_auto

    // Main sequence
    initial
    begin
        n_mismatch = 0;
        checks = 0;
        cyc = 0;
        slow = 1'b0;
        buttons = 6'h00;
        dig_in = 3'h0;
        start_req = 4'h0;
        multiset_comms_link = 8'h00;
        alarm_in = 8'h00;
        reg_req = '0;
        sys_rst = 1'b1;
        wait_cyc(5);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_stop();
        t_manual();
        t_auto();
        final_report();
    end
endmodule : genset_mode_sequencer_tb

`default_nettype wire
